/* bench/cmb_buffer_bank_test.sv */
// Purpose: self-checking bench for the message buffer bank
// Assumes: field model mem[] indexed buffer*32+field, all zero at reset
// Notes:   buffer 31 takes the remote frame and is never swept
`timescale 1ns/1ps

module cmb_buffer_bank_test
  import cmb_pkg::*;
;
  localparam logic [13:0] BASE_V = 14'h0005; // alias base of the run
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        rx_store, rx_ext, rx_remote, tx_done, tx_avail;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [7:0]  proto_clk_sel;
  logic [4:0]  rx_buf, tx_done_buf, tx_buf;
  logic [3:0]  rx_dlc, lag;
  logic [63:0] rx_data;
  logic [15:0] rx_idl, rx_idh, ts_count;
  logic [31:0] mem [0:1023];                    // field model
  int          failures, tests_run;
  int          flds [14] = '{0, 1, 4, 8, 9, 10, 11, 12, 13, 14, 15, 16, 18, 20};

  cmb_buffer_bank i_cmb_buffer_bank (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .proto_clk_sel, .rx_store, .rx_buf,
    .rx_ext, .rx_remote, .rx_dlc, .rx_data, .rx_idl, .rx_idh, .ts_count, .tx_done,
    .tx_done_buf, .tx_avail, .tx_buf);
  cmb_engine_model i_cmb_engine_model (.clk, .rstn, .tx_avail, .tx_buf, .lag,
    .rx_store, .rx_buf, .rx_ext, .rx_remote, .rx_dlc, .rx_data, .rx_idl, .rx_idh,
    .ts_count, .tx_done, .tx_done_buf);

  // ====================
  // helpers
  initial clk = 1'b0;
  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // buffer field address in alias al
  function automatic logic [31:0] ba(int b, int f, logic [1:0] al);
    logic [11:0] lo;
    lo = 12'(12'h800 + b * 32 + f);
    return {BASE_V, al, 2'b10, lo, 2'b00};
  endfunction

  // bits a field keeps; status ignores writes
  function automatic logic [31:0] fmask(int f);
    if (f == 0) return 32'h0000000F;
    if (f == 4 || f == 16 || f == 18) return 32'h0000FFFF;
    return 32'h000000FF;
  endfunction

  task automatic check(logic [31:0] got, exp, string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled
  task automatic apb(logic w, logic [31:0] a, d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 200) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wr(logic [31:0] a, d);
    apb(1'b1, a, d);
    check({31'h0, er}, 32'h0, "write error");
  endtask

  task automatic rdc(logic [31:0] a, exp, string what);
    apb(1'b0, a, 32'h0);
    check({31'h0, er}, 32'h0, "read error");
    check(rd, exp, what);
  endtask

  initial begin
    #4000000;
    failures++;
    stop_test();
  end

  // ====================
  // main sequence
  initial begin
    logic [63:0] d64;
    logic [15:0] st, ih;
    logic [31:0] v;
    int b, f, n;
    int q[$];
    {psel, penable, pwrite, rstn} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    lag = 4'h2;
    seed = 32'h703B;
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({irq, tx_avail, tx_buf, proto_clk_sel}, 32'h0, "reset outputs");
    rdc({28'h0, G_MASK, 2'b00}, 32'(MASK_RST), "mask reset");
    v = rnd() & 32'hFF;
    wr({28'h0, G_CLK_SEL, 2'b00}, v);
    rdc({28'h0, G_CLK_SEL, 2'b00}, v, "clock select");
    check({24'h0, proto_clk_sel}, v, "clock select port");
    apb(1'b0, ba(0, 0, 2'b00), 32'h0);
    check({31'h0, er}, 32'h1, "buffers before base");
    wr({28'h0, G_BASE, 2'b00}, {18'h0, BASE_V});
    wr({28'h0, G_BASE, 2'b00}, 32'h0009);
    rdc({28'h0, G_BASE, 2'b00}, {17'h0, 1'b1, BASE_V}, "base locked");
    wr({28'h0, G_EVT, 2'b00}, 32'h7);
    for (int k = 0; k < 24; k++) begin
      lag <= 4'(2 + rnd() % 12);
      b = rnd() % 31;
      f = flds[rnd() % 14];
      v = rnd();
      if (f == 0) v = v & 32'h0F;
      wr(ba(b, f, 2'(rnd())), v);
      mem[b * 32 + f] = v & fmask(f);
      q.push_back(b * 32 + f);
    end
    foreach (q[i]) rdc(ba(q[i] / 32, q[i] % 32, 2'(rnd())), mem[q[i]], "field");
    wr(ba(5, 21, 2'b01), 32'hFF);
    wr(ba(5, 22, 2'b00), 32'h0100);
    rdc(ba(5, 21, 2'b10), 32'h1, "state ready");
    repeat (4) @(posedge clk);
    check({31'h0, tx_avail}, 32'h0, "send without request");
    wr(ba(5, 22, 2'b11), 32'h0200);
    n = 0;
    while (tx_avail !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check({27'h0, tx_buf}, 32'h5, "offered buffer");
    while (tx_avail === 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, tx_avail}, 32'h0, "send ended");
    rdc(ba(5, 21, 2'b00), 32'h1, "request cleared");
    rdc(ba(5, 22, 2'b00), 32'h0, "set clear reads zero");
    rdc({28'h0, G_EVT, 2'b00}, 32'h2, "tx event");
    apb(1'b1, ba(3, 2, 2'b00), 32'h5);
    check({31'h0, er}, 32'h1, "unmapped field");
    rdc({28'h0, G_EVT, 2'b00}, 32'h6, "error event");
    wr({28'h0, G_EVT, 2'b00}, 32'h7);
    wr({28'h0, G_MASK, 2'b00}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      d64 = {rnd(), rnd()};
      ih = 16'(rnd());
      v = rnd() % 9;
      i_cmb_engine_model.store(5'(8 + k), 1'b0, 1'b0, 4'(v), d64, 16'(rnd()), ih, st);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1, "irq raised");
      rdc(ba(8 + k, 0, 2'b10), v, "byte count");
      rdc(ba(8 + k, 4, 2'b00), {16'h0, st}, "stamp");
      for (int j = 0; j < 8; j++) rdc(ba(8 + k, 8 + j, 2'b01), d64[8 * j +: 8], "byte");
      rdc(ba(8 + k, 16, 2'b00), {d64[5:0], d64[15:8], d64[23:22]}, "ident low");
      rdc(ba(8 + k, 18, 2'b00), {16'h0, ih[15:2], d64[7:6]}, "ident high");
      rdc(ba(8 + k, 21, 2'b00), 32'h4, "new data");
      wr({28'h0, G_EVT, 2'b00}, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq cleared");
    end
    wr({28'h0, G_MASK, 2'b00}, 32'h0);
    ih = 16'(rnd());
    v = rnd() & 32'hFFFF;
    i_cmb_engine_model.store(5'd31, 1'b1, 1'b1, 4'h8, 64'h0, v[15:0], ih, st);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "masked irq");
    rdc({28'h0, G_EVT, 2'b00}, 32'h1, "rx event");
    rdc(ba(31, 0, 2'b11), 32'h0, "remote count");
    rdc(ba(31, 4, 2'b00), {16'h0, st}, "remote stamp");
    rdc(ba(31, 16, 2'b00), v, "ext ident low");
    rdc(ba(31, 18, 2'b00), {16'h0, ih}, "ext ident high");
    stop_test();
  end
endmodule

/* bench/cmb_engine_model.sv */
// Purpose: protocol engine stand-in on the far side of the bank
// Assumes: same clock as the bank; strobes are one-cycle pulses
// Notes:   idle frame lines toggle so stale values never pass
`timescale 1ns/1ps

module cmb_engine_model (
  input  wire logic        clk,         // bank clock
  input  wire logic        rstn,        // async reset, active low
  input  wire logic        tx_avail,    // a buffer may start
  input  wire logic [4:0]  tx_buf,      // buffer offered
  input  wire logic [3:0]  lag,         // cycles a send lasts
  output logic             rx_store,    // frame store strobe
  output logic      [4:0]  rx_buf,      // target buffer
  output logic             rx_ext,      // extended identifier
  output logic             rx_remote,   // remote frame
  output logic      [3:0]  rx_dlc,      // length code
  output logic      [63:0] rx_data,     // payload
  output logic      [15:0] rx_idl,      // identifier low
  output logic      [15:0] rx_idh,      // identifier high
  output logic      [15:0] ts_count,    // time stamp counter
  output logic             tx_done,     // send finished
  output logic      [4:0]  tx_done_buf  // buffer sent
);
  logic hold; // frame lines owned by store

  // ====================
  // idle values at time zero
  initial begin
    {hold, rx_store, rx_ext, rx_remote, tx_done} = 5'h00;
    {rx_buf, rx_dlc, rx_data, rx_idl, rx_idh, tx_done_buf} = '0;
  end

  // free-running stamp counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ts_count <= 16'h0000;
    else
      ts_count <= ts_count + 16'h0001;
  end

  // between frames the lines change every cycle
  always @(posedge clk) begin
    if (!hold) begin
      {rx_ext, rx_remote, rx_buf, rx_dlc} <= ~{rx_ext, rx_remote, rx_buf, rx_dlc};
      {rx_data, rx_idl, rx_idh} <= ~{rx_data, rx_idl, rx_idh};
    end
  end

  // one received frame; hands back the stamp the bank sampled
  task automatic store(input logic [4:0] b, input logic ext, rem, input logic [3:0] dlc,
                       input logic [63:0] d, input logic [15:0] il, ih,
                       output logic [15:0] stamp);
    hold = 1'b1;
    @(posedge clk);
    rx_store  <= 1'b1;
    rx_buf    <= b;
    rx_ext    <= ext;
    rx_remote <= rem;
    rx_dlc    <= dlc;
    rx_data   <= d;
    rx_idl    <= il;
    rx_idh    <= ih;
    @(posedge clk);
    stamp = ts_count;
    rx_store <= 1'b0;
    hold = 1'b0;
  endtask

  // ====================
  // sender: waits out a stale offer after each send
  always begin
    @(posedge clk);
    if (rstn && tx_avail === 1'b1) begin
      repeat (lag) @(posedge clk);
      tx_done     <= 1'b1;
      tx_done_buf <= tx_buf;
      @(posedge clk);
      tx_done     <= 1'b0;
      tx_done_buf <= ~tx_done_buf;
      repeat (2) @(posedge clk);
    end
  end
endmodule

/* shared/cmb_pkg.sv */
// Purpose: constants and types shared by the message buffer bank
// Assumes: 32-bit APB, one register per aligned word, byte address = 4 x index
// Notes:   buffer field offsets are word indices relative to the buffer start
package cmb_pkg;

  // ==========================================================================
  // geometry
  localparam int NBUF = 32;                     // number of message buffers

  // ==========================================================================
  // global registers, word indices in paddr[3:2]
  localparam logic [1:0] G_CLK_SEL = 2'h0;      // protocol_clock_select
  localparam logic [1:0] G_BASE    = 2'h1;      // alias base, write-once
  localparam logic [1:0] G_EVT     = 2'h2;      // event status, write one to clear
  localparam logic [1:0] G_MASK    = 2'h3;      // event mask

  // ==========================================================================
  // buffer area decode, on the word index paddr[17:2]
  localparam logic [1:0] ALIAS_LOW = 2'h2;      // alias nibble low bits (2,6,A,E)
  localparam logic [1:0] BUF_AREA  = 2'h2;      // index 0x800 .. 0xBFF

  // ==========================================================================
  // field indices within one buffer (stride 0x20)
  localparam logic [4:0] F_DLC   = 5'h00;       // buf_byte_count
  localparam logic [4:0] F_CTRL  = 5'h01;       // buf_frame_format_ctl
  localparam logic [4:0] F_STAMP = 5'h04;       // buf_rx_stamp
  localparam logic [1:0] F_DATA  = 2'h1;        // fld[4:3]: payload bytes 0x08..0x0F
  localparam logic [4:0] F_IDL   = 5'h10;       // buf_ident_low
  localparam logic [4:0] F_IDH   = 5'h12;       // buf_ident_high
  localparam logic [4:0] F_CONF  = 5'h14;       // buf_type_mask_cfg
  localparam logic [4:0] F_STATE = 5'h15;       // buf_state, read only
  localparam logic [4:0] F_SC    = 5'h16;       // buf_state_set_clear, write only

  // ==========================================================================
  // buf_state bit positions
  localparam int ST_READY = 0;                  // buffer ready
  localparam int ST_TRQ   = 1;                  // tx_request_flag
  localparam int ST_NEW   = 2;                  // new data received

  // ==========================================================================
  // event bits and reset values
  localparam int EV_RX  = 0;                    // reception stored
  localparam int EV_TX  = 1;                    // transmission done
  localparam int EV_ERR = 2;                    // bus access error
  localparam logic [7:0] CLK_SEL_RST = 8'h00;   // protocol clock select reset
  localparam logic [2:0] MASK_RST    = 3'h0;    // all events masked

  // ==========================================================================
  // whole state of the bank
  typedef struct packed {
    logic [NBUF-1:0][7:0]       dlc;            // byte counts
    logic [NBUF-1:0][7:0]       ctrl;           // frame format controls
    logic [NBUF-1:0][7:0]       conf;           // type and mask configs
    logic [NBUF-1:0][7:0]       state;          // status bytes
    logic [NBUF-1:0][15:0]      stamp;          // receive time stamps
    logic [NBUF-1:0][15:0]      idl;            // identifier low words
    logic [NBUF-1:0][15:0]      idh;            // identifier high words
    logic [NBUF-1:0][7:0][7:0]  data;           // payload bytes
    logic [7:0]                 clk_sel;        // protocol clock select
    logic [13:0]                base;           // alias base address bits
    logic                       base_set;       // base locked
    logic [2:0]                 evt;            // sticky events
    logic [2:0]                 mask;           // event mask
    logic                       ready;          // apb pready
    logic                       slverr;         // apb pslverr
    logic [31:0]                rdata;          // apb prdata
    logic                       irq;            // interrupt line
    logic                       tx_avail;       // a buffer may be sent
    logic [4:0]                 tx_buf;         // which buffer
  } cmb_state_type;

endpackage

/* src/cmb_buffer_bank.sv */
// Purpose: message buffer bank of a CAN controller behind an APB slave
// Assumes: protocol engine and APB on clk; engine strobes are one-cycle pulses
// Notes:   one packed state struct, one comb process, one flop process
//
// What this block does
// - eight-bit protocol clock select register
// - reception writes received byte count
// - extended remote frame stores zero count
// - per-buffer eight-bit frame format control
// - reception completion copies time stamp counter
// - eight payload bytes per buffer
// - identifier held in low/high 16-bit words
// - standard mode packs data into identifier
// - per-buffer type and mask configuration
// - status byte read only, writes ignored
// - transmit only with request and ready set
// - alias base programmable, then locked
// - set/clear register write only, changes status
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module cmb_buffer_bank
  import cmb_pkg::*;
(
  input  wire logic        clk,          // 10 MHz clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [31:0] paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error
  output logic             irq,          // level interrupt
  output logic      [7:0]  proto_clk_sel, // protocol clock select
  input  wire logic        rx_store,     // engine stores a frame
  input  wire logic [4:0]  rx_buf,       // target buffer
  input  wire logic        rx_ext,       // extended identifier
  input  wire logic        rx_remote,    // remote frame
  input  wire logic [3:0]  rx_dlc,       // length code from bus
  input  wire logic [63:0] rx_data,      // payload, byte 0 in [7:0]
  input  wire logic [15:0] rx_idl,       // identifier low word
  input  wire logic [15:0] rx_idh,       // identifier high word
  input  wire logic [15:0] ts_count,     // time stamp counter
  input  wire logic        tx_done,      // engine finished a transmit
  input  wire logic [4:0]  tx_done_buf,  // buffer just sent
  output logic             tx_avail,     // a buffer may start
  output logic      [4:0]  tx_buf        // lowest such buffer
);

  // ==========================================================================
  // helpers
  // both gating bits of a status byte
  function automatic logic tx_ok(input logic [7:0] st);
    return st[ST_TRQ] & st[ST_READY];
  endfunction

  // set/clear word: high byte sets, low byte clears, both or none keeps
  function automatic logic [7:0] sc_apply(input logic [7:0] st, input logic [15:0] w);
    return (st & ~(w[7:0] & ~w[15:8])) | (w[15:8] & ~w[7:0]);
  endfunction

  // ==========================================================================
  // state
  cmb_state_type s;                      // registered state
  cmb_state_type next_s;                 // next state
  logic          acc;                    // apb access phase
  logic          done;                   // access completes this edge
  logic          is_glb;                 // global register hit
  logic          is_buf;                 // buffer area hit
  logic [15:0]   idx;                    // word index
  logic [4:0]    b;                      // addressed buffer
  logic [4:0]    fld;                    // field within buffer
  logic          conflict;               // engine writes addressed buffer
  logic [31:0]   rd;                     // decoded read value
  logic          err;                    // decoded unmapped access
  logic [2:0]    evt_set;                // events this cycle
  logic [2:0]    evt_clr;                // software clears this cycle

  // ==========================================================================
  // next state
  always_comb begin
    next_s   = s;
    acc      = psel & penable;
    done     = acc & s.ready;
    idx      = paddr[17:2];
    is_glb   = (paddr[31:4] == 28'h0000000);
    is_buf   = s.base_set && (paddr[31:18] == s.base) &&
               (idx[13:12] == ALIAS_LOW) && (idx[11:10] == BUF_AREA);
    b        = idx[9:5];
    fld      = idx[4:0];
    conflict = rx_store && is_buf && (b == rx_buf);
    rd       = 32'h00000000;
    err      = 1'b0;
    evt_set  = 3'h0;
    evt_clr  = 3'h0;

    // read decode, also marks unmapped addresses
    if (is_glb) begin
      unique case (paddr[3:2])
        G_CLK_SEL: rd = {24'h000000, s.clk_sel};
        G_BASE:    rd = {17'h00000, s.base_set, s.base};
        G_EVT:     rd = {29'h00000000, s.evt};
        G_MASK:    rd = {29'h00000000, s.mask};
      endcase
    end else if (is_buf) begin
      if (fld[4:3] == F_DATA) begin
        rd = {24'h000000, s.data[b][fld[2:0]]};
      end else begin
        case (fld)
          F_DLC:   rd = {24'h000000, s.dlc[b]};
          F_CTRL:  rd = {24'h000000, s.ctrl[b]};
          F_STAMP: rd = {16'h0000, s.stamp[b]};
          F_IDL:   rd = {16'h0000, s.idl[b]};
          F_IDH:   rd = {16'h0000, s.idh[b]};
          F_CONF:  rd = {24'h000000, s.conf[b]};
          F_STATE: rd = {24'h000000, s.state[b]};
          F_SC:    rd = 32'h00000000;    // write only, reads zero
          default: err = 1'b1;           // hole in the buffer layout
        endcase
      end
    end else begin
      err = 1'b1;                        // nothing mapped here
    end

    // handshake: one wait cycle, longer while the engine owns the buffer,
    // so a read never catches a field half updated
    next_s.ready  = acc & ~s.ready & ~conflict;
    next_s.slverr = acc & ~s.ready & ~conflict & err;
    if (acc & ~s.ready & ~conflict) begin
      next_s.rdata = rd;                 // snapshot taken in a quiet cycle
    end

    // cpu writes land at the completing edge
    if (done && pwrite && !s.slverr) begin
      if (is_glb) begin
        unique case (paddr[3:2])
          G_CLK_SEL: next_s.clk_sel = pwdata[7:0];
          G_BASE: begin
            if (!s.base_set) begin       // first write wins for good
              next_s.base     = pwdata[13:0];
              next_s.base_set = 1'b1;
            end
          end
          G_EVT:  evt_clr = pwdata[2:0];
          G_MASK: next_s.mask = pwdata[2:0];
        endcase
      end else if (fld[4:3] == F_DATA) begin
        next_s.data[b][fld[2:0]] = pwdata[7:0];
      end else begin
        case (fld)
          F_DLC:   next_s.dlc[b]   = {4'h0, pwdata[3:0]}; // reserved bits read zero
          F_CTRL:  next_s.ctrl[b]  = pwdata[7:0];
          F_STAMP: next_s.stamp[b] = pwdata[15:0];
          F_IDL:   next_s.idl[b]   = pwdata[15:0];
          F_IDH:   next_s.idh[b]   = pwdata[15:0];
          F_CONF:  next_s.conf[b]  = pwdata[7:0];
          F_SC:    next_s.state[b] = sc_apply(s.state[b], pwdata[15:0]);
          default: ;                     // status byte ignores writes
        endcase
      end
    end
    if (done && s.slverr) begin
      evt_set[EV_ERR] = 1'b1;
    end

    // engine finished a transmit: request drops
    if (tx_done) begin
      next_s.state[tx_done_buf][ST_TRQ] = 1'b0;
      evt_set[EV_TX] = 1'b1;
    end

    // engine stores a frame; applied last so it wins over a cpu write
    if (rx_store) begin
      next_s.dlc[rx_buf]   = (rx_ext && rx_remote) ? 8'h00 : {4'h0, rx_dlc};
      next_s.stamp[rx_buf] = ts_count;
      next_s.data[rx_buf]  = rx_data;
      if (rx_ext) begin
        next_s.idl[rx_buf] = rx_idl;
        next_s.idh[rx_buf] = rx_idh;
      end else begin
        // spare extended bits hold bytes zero, one and top of two:
        // byte zero spans idh[1:0] and idl[15:10], so it straddles words
        next_s.idl[rx_buf] = {rx_data[5:0], rx_data[15:8], rx_data[23:22]};
        next_s.idh[rx_buf] = {rx_idh[15:2], rx_data[7:6]};
      end
      next_s.state[rx_buf][ST_NEW] = 1'b1;
      evt_set[EV_RX] = 1'b1;
    end

    // sticky events: a new event beats a clear in the same cycle
    next_s.evt = (s.evt & ~evt_clr) | evt_set;
    next_s.irq = |(next_s.evt & next_s.mask);

    // lowest buffer holding both request and ready
    next_s.tx_avail = 1'b0;
    next_s.tx_buf   = 5'h00;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (tx_ok(next_s.state[i])) begin
        next_s.tx_avail = 1'b1;
        next_s.tx_buf   = 5'(i);
      end
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s         <= '0;
      s.clk_sel <= CLK_SEL_RST;
      s.mask    <= MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign prdata        = s.rdata;
  assign pready        = s.ready;
  assign pslverr       = s.slverr;
  assign irq           = s.irq;
  assign proto_clk_sel = s.clk_sel;
  assign tx_avail      = s.tx_avail;
  assign tx_buf        = s.tx_buf;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wr_done;
    psel && penable && pready && pwrite && !pslverr;
  endsequence

  sequence s_sc_clr_trq;
    s_wr_done ##0 is_buf && fld == F_SC && pwdata[ST_TRQ] && !pwdata[8 + ST_TRQ];
  endsequence

  chk_tx_gate: assert property (tx_avail |-> tx_ok(s.state[tx_buf]))
    else $error("transmit offered without request and ready");

  chk_rx_count: assert property (rx_store |=>
    s.dlc[$past(rx_buf)] == (($past(rx_ext) && $past(rx_remote)) ? 8'h00
                             : {4'h0, $past(rx_dlc)}))
    else $error("received byte count wrong");

  chk_rx_stamp: assert property (rx_store |=> s.stamp[$past(rx_buf)] == $past(ts_count))
    else $error("time stamp not captured");

  chk_std_pack: assert property (rx_store && !rx_ext |=>
    {s.idh[$past(rx_buf)][1:0], s.idl[$past(rx_buf)]} ==
    {$past(rx_data[7:0]), $past(rx_data[15:8]), $past(rx_data[23:22])})
    else $error("standard frame data not packed into identifier");

  chk_clk_sel: assert property (s_wr_done ##0 is_glb && paddr[3:2] == G_CLK_SEL |=>
    proto_clk_sel == $past(pwdata[7:0]))
    else $error("clock select not written");

  chk_base_lock: assert property (s.base_set |=> s.base_set && $stable(s.base))
    else $error("alias base changed after lock");

  chk_arb_hold: assert property (psel && penable && !pready && conflict |=> !pready)
    else $error("access completed during engine update");

  chk_state_ro: assert property (s_wr_done ##0 is_buf && fld == F_STATE && !rx_store &&
    !tx_done |=> $stable(s.state))
    else $error("status byte changed by direct write");

  chk_sc_clear: assert property (s_sc_clr_trq |=> !s.state[$past(b)][ST_TRQ])
    else $error("set/clear failed to drop request");

  chk_irq_level: assert property (irq == |(s.evt & s.mask))
    else $error("interrupt line disagrees with status and mask");

  chk_wait_state: assert property (psel && penable && !pready && !conflict |=> pready)
    else $error("access not answered after one wait");

endmodule
